/* File: common/adcrs_regs.vh */
// register map, field positions and reset values of the result store
`ifndef ADCRS_REGS_VH
`define ADCRS_REGS_VH
`define ADCRS_OFS_SLOT0 8'h00
`define ADCRS_OFS_SLOT1 8'h04
`define ADCRS_OFS_SLOT2 8'h08
`define ADCRS_OFS_SLOT3 8'h0c
`define ADCRS_OFS_IRQ_STAT 8'h10
`define ADCRS_OFS_IRQ_MASK 8'h14
`define ADCRS_VAL_MSB 15
`define ADCRS_VAL_LSB 4
`define ADCRS_OVR_BIT 1
`define ADCRS_RF_BIT 0
`define ADCRS_NSLOT 4
`define ADCRS_RESET_WORD 32'h00000000
`define ADCRS_STAT_RESET 8'h00
`define ADCRS_ADDR_W 8
`endif

/* File: rtl/adcrs_irq.v */
// sticky event status, mask and level interrupt
`timescale 1ns/100ps
`include "adcrs_regs.vh"
module adcrs_irq (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] event_i,
    input wire stat_wr_i,
    input wire mask_wr_i,
    input wire [7:0] wdata_i,
    output reg [7:0] stat_o,
    output reg [7:0] mask_o,
    output wire irq_o
);
    always @(posedge clk_i) begin
        if (rst_i) begin
            stat_o <= `ADCRS_STAT_RESET;
            mask_o <= `ADCRS_STAT_RESET;
        end else begin
            // new events win over a write-one clear
            if (stat_wr_i) begin
                stat_o <= (stat_o & ~wdata_i) | event_i;
            end else begin
                stat_o <= stat_o | event_i;
            end
            if (mask_wr_i) begin
                mask_o <= wdata_i;
            end
        end
    end
    assign irq_o = |(stat_o & mask_o);
endmodule // adcrs_irq

/* File: rtl/adcrs_slot.v */
// one conversion result slot with stored and overrun flags
`timescale 1ns/100ps
`include "adcrs_regs.vh"
module adcrs_slot (
    input wire clk_i,
    input wire rst_i,
    input wire store_i,
    input wire [11:0] value_i,
    input wire clr_stored_i,
    input wire clr_ovr_i,
    output reg [11:0] value_o,
    output reg stored_o,
    output reg ovr_o
);
    always @(posedge clk_i) begin
        if (rst_i) begin
            value_o <= 12'h000;
            stored_o <= 1'b0;
            ovr_o <= 1'b0;
        end else begin
            if (store_i) begin
                value_o <= value_i;
            end
            // a store in the read cycle wins over the clear
            if (store_i) begin
                stored_o <= 1'b1;
            end else if (clr_stored_i) begin
                stored_o <= 1'b0;
            end
            if (store_i && stored_o) begin
                ovr_o <= 1'b1;
            end else if (clr_ovr_i) begin
                ovr_o <= 1'b0;
            end
        end
    end
endmodule // adcrs_slot

/* File: rtl/adcrs_top.v */
// conversion result store: four slots behind a classic wishbone slave
`timescale 1ns/100ps
`include "adcrs_regs.vh"
module adcrs_top (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output wire wb_err_o,
    input wire conv_store_i,
    input wire [1:0] conv_slot_i,
    input wire [11:0] conv_value_i,
    output wire irq_o
);
    // bus phases: a request is taken in idle and answered in the next cycle
    localparam BUS_IDLE = 1'b0;
    localparam BUS_ANSWER = 1'b1;

    wire [11:0] val0;
    wire [11:0] val1;
    wire [11:0] val2;
    wire [11:0] val3;
    wire [3:0] stored;
    wire [3:0] ovr;
    wire [3:0] clr_stored;
    wire [3:0] clr_ovr;

    wire [3:0] ev_done;
    wire [3:0] ev_ovr;
    wire [7:0] events;
    wire [7:0] stat;
    wire [7:0] mask;
    wire [7:0] wr_byte;

    wire req;
    wire rd_take;
    wire wr_take;
    wire [3:0] slot_adr;
    wire [3:0] rd_hit;
    wire stat_adr;
    wire mask_adr;
    wire mapped;
    wire stat_wr;
    wire mask_wr;

    wire [31:0] word0;
    wire [31:0] word1;
    wire [31:0] word2;
    wire [31:0] word3;
    reg [3:0] store;
    reg bus_state_r;
    reg bus_state_nxt;
    reg [31:0] rdata;
    reg [31:0] dat_nxt;

    // one slot register image; everything outside the fields reads zero
    function [31:0] slot_word;
        input [11:0] v;
        input o;
        input f;
        begin
            slot_word = `ADCRS_RESET_WORD;
            slot_word[`ADCRS_VAL_MSB:`ADCRS_VAL_LSB] = v;
            slot_word[`ADCRS_OVR_BIT] = o;
            slot_word[`ADCRS_RF_BIT] = f;
        end
    endfunction

    // full compare: an alias would clear a slot's flags by surprise
    function adr_is;
        input [`ADCRS_ADDR_W-1:0] a;
        input [`ADCRS_ADDR_W-1:0] ofs;
        begin
            adr_is = (a == ofs);
        end
    endfunction

    // one-hot slot select from a bus address
    function [3:0] slot_onehot;
        input [`ADCRS_ADDR_W-1:0] a;
        begin
            slot_onehot[0] = adr_is(a, `ADCRS_OFS_SLOT0);
            slot_onehot[1] = adr_is(a, `ADCRS_OFS_SLOT1);
            slot_onehot[2] = adr_is(a, `ADCRS_OFS_SLOT2);
            slot_onehot[3] = adr_is(a, `ADCRS_OFS_SLOT3);
        end
    endfunction

    // anything else answers zero and ignores writes
    function is_mapped;
        input [`ADCRS_ADDR_W-1:0] a;
        begin
            is_mapped = (|slot_onehot(a)) |
                        adr_is(a, `ADCRS_OFS_IRQ_STAT) |
                        adr_is(a, `ADCRS_OFS_IRQ_MASK);
        end
    endfunction

    // the ack lasts one cycle, so one ack answers exactly one request
    always @* begin
        bus_state_nxt = BUS_IDLE;
        case (bus_state_r)
            BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    bus_state_nxt = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                bus_state_nxt = BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    // a request is taken on the edge that sees it in idle
    assign req = wb_cyc_i & wb_stb_i & (bus_state_r == BUS_IDLE);
    assign rd_take = req & ~wb_we_i;
    assign wr_take = req & wb_we_i;
    assign slot_adr = slot_onehot(wb_adr_i);
    assign stat_adr = adr_is(wb_adr_i, `ADCRS_OFS_IRQ_STAT);
    assign mask_adr = adr_is(wb_adr_i, `ADCRS_OFS_IRQ_MASK);
    assign mapped = is_mapped(wb_adr_i);
    // unmapped reads answer zero; an error would stall simple masters
    assign wb_err_o = 1'b0;

    assign rd_hit = {4{rd_take}} & slot_adr;
    // slot zero only lets go of its stored flag when byte lane 0 is read
    assign clr_stored[0] = rd_hit[0] & wb_sel_i[0];
    assign clr_stored[3:1] = rd_hit[3:1];
    assign clr_ovr = rd_hit;
    // only byte lane 0 of status and mask holds bits
    assign wr_byte = wb_dat_i[7:0];
    assign stat_wr = wr_take & stat_adr & wb_sel_i[0];
    assign mask_wr = wr_take & mask_adr & wb_sel_i[0];

    // a slot number selects one store strobe
    always @* begin
        store = 4'h0;
        case (conv_slot_i)
            2'h0: begin
                store[0] = conv_store_i;
            end
            2'h1: begin
                store[1] = conv_store_i;
            end
            2'h2: begin
                store[2] = conv_store_i;
            end
            2'h3: begin
                store[3] = conv_store_i;
            end
            default: begin
                store = 4'h0;
            end
        endcase
    end

    // four identical slots; only the stored-flag clear strobe tells slot zero apart
    adcrs_slot u_slot0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .store_i(store[0]),
        .value_i(conv_value_i),
        .clr_stored_i(clr_stored[0]),
        .clr_ovr_i(clr_ovr[0]),
        .value_o(val0),
        .stored_o(stored[0]),
        .ovr_o(ovr[0])
    );

    adcrs_slot u_slot1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .store_i(store[1]),
        .value_i(conv_value_i),
        .clr_stored_i(clr_stored[1]),
        .clr_ovr_i(clr_ovr[1]),
        .value_o(val1),
        .stored_o(stored[1]),
        .ovr_o(ovr[1])
    );

    adcrs_slot u_slot2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .store_i(store[2]),
        .value_i(conv_value_i),
        .clr_stored_i(clr_stored[2]),
        .clr_ovr_i(clr_ovr[2]),
        .value_o(val2),
        .stored_o(stored[2]),
        .ovr_o(ovr[2])
    );

    adcrs_slot u_slot3 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .store_i(store[3]),
        .value_i(conv_value_i),
        .clr_stored_i(clr_stored[3]),
        .clr_ovr_i(clr_ovr[3]),
        .value_o(val3),
        .stored_o(stored[3]),
        .ovr_o(ovr[3])
    );

    // events: bits 3..0 result stored, bits 7..4 overrun per slot
    assign ev_done = store;
    assign ev_ovr = store & stored;
    assign events = {ev_ovr, ev_done};

    // status bits are sticky; writing a one clears them
    adcrs_irq u_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .event_i(events),
        .stat_wr_i(stat_wr),
        .mask_wr_i(mask_wr),
        .wdata_i(wr_byte),
        .stat_o(stat),
        .mask_o(mask),
        .irq_o(irq_o)
    );

    assign word0 = slot_word(val0, ovr[0], stored[0]);
    assign word1 = slot_word(val1, ovr[1], stored[1]);
    assign word2 = slot_word(val2, ovr[2], stored[2]);
    assign word3 = slot_word(val3, ovr[3], stored[3]);

    always @* begin
        rdata = `ADCRS_RESET_WORD;
        case (wb_adr_i)
            `ADCRS_OFS_SLOT0: begin
                rdata = word0;
            end
            `ADCRS_OFS_SLOT1: begin
                rdata = word1;
            end
            `ADCRS_OFS_SLOT2: begin
                rdata = word2;
            end
            `ADCRS_OFS_SLOT3: begin
                rdata = word3;
            end
            `ADCRS_OFS_IRQ_STAT: begin
                rdata = {24'h000000, stat};
            end
            `ADCRS_OFS_IRQ_MASK: begin
                rdata = {24'h000000, mask};
            end
            default: begin
                rdata = `ADCRS_RESET_WORD;
            end
        endcase
    end

    // read data stands until the next read is taken
    always @* begin
        dat_nxt = wb_dat_o;
        if (rd_take) begin
            if (mapped) begin
                dat_nxt = rdata;
            end else begin
                dat_nxt = `ADCRS_RESET_WORD;
            end
        end
    end

    // ack mirrors the answer phase, so it drops in the following cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            bus_state_r <= BUS_IDLE;
            wb_ack_o <= 1'b0;
        end else begin
            bus_state_r <= bus_state_nxt;
            wb_ack_o <= (bus_state_nxt == BUS_ANSWER);
        end
    end

    // flags clear at the same edge that captures the data
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= `ADCRS_RESET_WORD;
        end else begin
            wb_dat_o <= dat_nxt;
        end
    end
endmodule // adcrs_top

/* File: verification/adcrs_checker.sv */
// port assertions for the conversion result store
`timescale 1ns/100ps
module adcrs_checker (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire conv_store_i,
    input wire [1:0] conv_slot_i,
    input wire [11:0] conv_value_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    sequence dbl_store;
        conv_store_i && !wb_stb_i ##1
            (conv_store_i && !wb_stb_i && $stable(conv_slot_i));
    endsequence
    // a second read of the same register with no store in between
    property reread(c, m);
        c && rd && !conv_store_i ##1 (!conv_store_i) [*2]
            ##1 (rd && wb_adr_i == $past(wb_adr_i, 3))
            |=> (wb_dat_o[1:0] & m) == 2'b00;
    endproperty
    ack_timing_a: assert property (rd |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");
    unused_zero_a: assert property (wb_ack_o && !$past(wb_we_i) &&
        $past(wb_adr_i) < 8'h10 |-> wb_dat_o[31:16] == 16'h0 &&
        wb_dat_o[3:2] == 2'h0) else $error("unused slot bits set");
    store_seen_a: assert property (rd && $past(conv_store_i) &&
        wb_adr_i == {4'h0, $past(conv_slot_i), 2'b00} |=> wb_dat_o[0] &&
        wb_dat_o[15:4] == $past(conv_value_i, 2))
        else $error("stored result not shown");
    overrun_set_a: assert property (dbl_store ##1 (rd &&
        wb_adr_i == {4'h0, $past(conv_slot_i), 2'b00}) |=> wb_dat_o[1])
        else $error("overrun flag missing");
    clr_slot_a: assert property (reread(wb_adr_i inside
        {8'h04, 8'h08, 8'h0c}, 2'b11)) else $error("slot flags kept");
    clr_zero_a: assert property (reread(wb_adr_i == 8'h00 &&
        wb_sel_i[0], 2'b01)) else $error("slot zero stored flag kept");
    ovr_zero_a: assert property (reread(wb_adr_i == 8'h00, 2'b10))
        else $error("slot zero overrun kept");
endmodule // adcrs_checker
bind adcrs_top adcrs_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .conv_store_i,
    .conv_slot_i, .conv_value_i);

/* File: verification/adcrs_seq_model.sv */
// conversion sequencer model that stores results
`timescale 1ns/100ps
module adcrs_seq_model (
    input wire clk_i,
    output reg conv_store_o = 1'b0,
    output reg [1:0] conv_slot_o = 2'h0,
    output reg [11:0] conv_value_o = 12'h000
);
    // n stores back to back after d idle cycles
    task burst(input [1:0] s, input [11:0] v, input int n, input int d);
        repeat (d) @(posedge clk_i);
        repeat (n) begin
            @(posedge clk_i);
            conv_store_o <= 1'b1;
            conv_slot_o <= s;
            conv_value_o <= v;
            v = v + 12'h001;
        end
        @(posedge clk_i);
        conv_store_o <= 1'b0;
        // no stale value left standing between stores
        conv_value_o <= ~conv_value_o;
    endtask
endmodule // adcrs_seq_model

/* File: verification/test_adcrs_top.sv */
// self-checking bench for the conversion result store
`timescale 1ns/100ps
`include "adcrs_regs.vh"
module test_adcrs_top;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [3:0] sel = 4'hf;
    reg [31:0] wdat = 32'h0;
    wire [31:0] rdat;
    wire ack, st, irq, err;
    wire [1:0] sl;
    wire [11:0] val;
    int n_mismatch = 0;
    int num_checks = 0;
    adcrs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .conv_store_i(st), .conv_slot_i(sl), .conv_value_i(val),
        .irq_o(irq));
    adcrs_seq_model seq (.clk_i(clk_i), .conv_store_o(st),
        .conv_slot_o(sl), .conv_value_o(val));
    task check(input [31:0] got, input [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d, input [31:0] exp);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        cyc <= 1'b0;
        if (!w) check(rdat, exp);
        check({31'h0, err}, 32'h0);
        @(posedge clk_i);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial forever #12.5 clk_i = ~clk_i;
    initial begin
        #100000;
        n_mismatch++;
        close_out;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 7; i++) bus(0, 8'(i * 4), 0, 0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            seq.burst(2'(i), 12'h5a0 + 12'(i), 1, 0);
            bus(0, 8'(i * 4), 0, {16'h0, 12'h5a0 + 12'(i), 4'h1});
            bus(0, 8'(i * 4), 0, {16'h0, 12'h5a0 + 12'(i), 4'h0});
        end
        bus(1, `ADCRS_OFS_SLOT1, 32'hffffffff, 0);
        bus(0, `ADCRS_OFS_SLOT1, 0, 32'h00005a10);
        $display("test slots done");
        seq.burst(2'h2, 12'h123, 2, 3);
        bus(0, `ADCRS_OFS_SLOT2, 0, 32'h00001243);
        bus(0, `ADCRS_OFS_SLOT2, 0, 32'h00001240);
        seq.burst(2'h0, 12'h7ff, 2, 0);
        sel <= 4'he;
        bus(0, `ADCRS_OFS_SLOT0, 0, 32'h00008003);
        sel <= 4'hf;
        bus(0, `ADCRS_OFS_SLOT0, 0, 32'h00008001);
        bus(0, `ADCRS_OFS_SLOT0, 0, 32'h00008000);
        $display("test overrun done");
        bus(0, `ADCRS_OFS_IRQ_STAT, 0, 32'h5f);
        check({31'h0, irq}, 32'h0);
        bus(1, `ADCRS_OFS_IRQ_MASK, 32'h10, 0);
        check({31'h0, irq}, 32'h1);
        bus(1, `ADCRS_OFS_IRQ_STAT, 32'h10, 0);
        check({31'h0, irq}, 32'h0);
        bus(0, `ADCRS_OFS_IRQ_STAT, 0, 32'h4f);
        $display("test irq done");
        close_out;
    end
endmodule // test_adcrs_top
